// ===== include/popc_pkg.sv
// package: constants, types and register map of the pwm output pin control block
//------------------------------------------------------------------------------
// Notes on behaviour
// - exchange bit swaps high and low waveforms
// - exchange waits for cycle boundary when sync set and module enabled
// - exchange happens before dead-time insertion
// - protected write must be very next access
// - key register write-only, reads return zero
// - configuration setting disables write protection
// - priority: generator, exchange, manual, limit, fault, ownership
// - disabled module hands both pins to gpio
// - bits 15 and 14 give pin ownership
// - force enables bits 9, 8 replace generator output
// - force levels bits 7:6 drive overridden pins
// - overrides feed the dead-time unit control inputs
// - sync set: exchange and force changes load at time-base zero while enabled
// - fault levels beat limit levels beat manual
// - zero levels bypass dead time, ones pass it
//------------------------------------------------------------------------------
package popc_pkg;

  //----------------------------------------------------------------------------
  // register map, byte addresses
  //----------------------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FAULT_CTRL = 8'h04;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MODULE_CTRL = 8'h10;

  // unlock key words
  localparam logic [15:0] KEY_FIRST = 16'habcd;
  localparam logic [15:0] KEY_SECOND = 16'h4321;
  localparam logic [15:0] KEY_READ_VALUE = 16'h0000;

  // values after reset
  localparam logic [15:0] RESET_PIN_CTRL = 16'h0000;
  localparam logic [15:0] RESET_FAULT_CTRL = 16'h0000;
  localparam logic [1:0] RESET_MODULE_CTRL = 2'h0;

  // module control field positions
  localparam int MCTRL_ENABLE_BIT = 0;
  localparam int MCTRL_BYPASS_BIT = 1;

  //----------------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic high_pin_own;
    logic low_pin_own;
    logic high_polarity;
    logic low_polarity;
    logic [1:0] rsvd;
    logic high_force_en;
    logic low_force_en;
    logic [1:0] force_levels;
    logic [1:0] fault_levels;
    logic [1:0] limit_levels;
    logic swap;
    logic override_sync;
  } popc_pin_ctrl_t;

  typedef struct packed {
    logic high;
    logic low;
  } popc_pair_t;

  typedef enum logic [2:0] {
    UNLOCK_IDLE = 3'b001,
    UNLOCK_FIRST = 3'b010,
    UNLOCK_OPEN = 3'b100
  } popc_unlock_state_t;

endpackage

// ===== hdl/popc_unlock.sv
// unlock tracker for the protected registers
`timescale 1ns/1ns
module popc_unlock (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // completed register access
  input wire logic access_i,
  input wire logic key_write_i,
  input wire logic [15:0] key_data_i,
  input wire logic bypass_i,
  // result
  output logic write_ok_o,
  output logic unlocked_o
);
  popc_pkg::popc_unlock_state_t state;
  popc_pkg::popc_unlock_state_t next_state;

  always_comb begin
    next_state = state;
    if (access_i) begin
      case (state)
        popc_pkg::UNLOCK_IDLE: begin
          next_state = popc_pkg::UNLOCK_IDLE;
        end
        popc_pkg::UNLOCK_FIRST: begin
          next_state = (key_write_i && key_data_i == popc_pkg::KEY_SECOND) ?
                       popc_pkg::UNLOCK_OPEN : popc_pkg::UNLOCK_IDLE;
        end
        default: begin
          next_state = popc_pkg::UNLOCK_IDLE;
        end
      endcase
      // a fresh first word restarts the sequence from anywhere
      if (key_write_i && key_data_i == popc_pkg::KEY_FIRST) begin
        next_state = popc_pkg::UNLOCK_FIRST;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= popc_pkg::UNLOCK_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // open only for the access right after the key pair
  assign unlocked_o = (state == popc_pkg::UNLOCK_OPEN);
  assign write_ok_o = bypass_i || unlocked_o;

  a_open_single: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (unlocked_o && access_i) |=> !unlocked_o)
    else $error("unlock stayed open after an access");

  a_key_pair: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (access_i && state == popc_pkg::UNLOCK_FIRST && key_write_i &&
     key_data_i == popc_pkg::KEY_SECOND) |=> unlocked_o)
    else $error("key pair did not unlock");
endmodule

// ===== hdl/popc_top.sv
// pwm output pin control: exchange, overrides, ownership and key-protected registers
`timescale 1ns/1ns
module popc_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // generator and protection inputs
  input wire logic gen_high_i,
  input wire logic gen_low_i,
  input wire logic fault_active_i,
  input wire logic limit_active_i,
  input wire logic tb_zero_i,
  // dead-time unit
  output logic dt_high_o,
  output logic dt_low_o,
  input wire logic dt_high_i,
  input wire logic dt_low_i,
  // gpio fallback levels
  input wire logic gpio_high_i,
  input wire logic gpio_low_i,
  // output pins
  output logic high_side_out_o,
  output logic low_side_out_o
);
  //----------------------------------------------------------------------------
  // registers
  //----------------------------------------------------------------------------
  popc_pkg::popc_pin_ctrl_t pin_ctrl;
  logic [15:0] fault_limit_control;
  logic [1:0] module_ctrl;
  logic ack;
  logic module_enable;
  logic bypass;
  logic write_ok;
  logic unlocked;

  // shadowed copies that drive the pins
  logic act_swap;
  logic act_high_force_en;
  logic act_low_force_en;
  logic [1:0] act_force_levels;

  popc_pkg::popc_pair_t swapped;
  popc_pkg::popc_pair_t next_dt;
  popc_pkg::popc_pair_t next_pin;

  // bus decode
  logic bus_req;
  logic bus_done;
  logic bus_wr;
  logic key_wr;
  logic key_word;

  assign module_enable = module_ctrl[popc_pkg::MCTRL_ENABLE_BIT];
  assign bypass = module_ctrl[popc_pkg::MCTRL_BYPASS_BIT];

  //----------------------------------------------------------------------------
  // functions
  //----------------------------------------------------------------------------
  // merge the low half-word under its byte lanes
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [15:0] res;
    res = old_v;
    if (sel[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr);
    return adr == reg_adr;
  endfunction

  //----------------------------------------------------------------------------
  // wishbone handshake
  //----------------------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i;
  // the access counts at the edge where the master sees ack
  assign bus_done = bus_req && ack;
  assign bus_wr = bus_done && wb_we_i;
  // key words only count as full low half-word writes
  assign key_word = wb_sel_i[1:0] == 2'h3;
  assign key_wr = bus_wr && hit(wb_adr_i, popc_pkg::ADDR_UNLOCK_KEY) && key_word;
  assign wb_ack_o = ack;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req && !ack;
    end
  end

  // read data is latched on the request edge so it stands with ack
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !ack && !wb_we_i) begin
      case (wb_adr_i)
        popc_pkg::ADDR_PIN_CTRL: begin
          wb_dat_o <= {16'h0000, pin_ctrl};
        end
        popc_pkg::ADDR_FAULT_CTRL: begin
          wb_dat_o <= {16'h0000, fault_limit_control};
        end
        popc_pkg::ADDR_UNLOCK_KEY: begin
          wb_dat_o <= {16'h0000, popc_pkg::KEY_READ_VALUE};
        end
        popc_pkg::ADDR_STATUS: begin
          wb_dat_o <= {24'h000000, high_side_out_o, low_side_out_o, limit_active_i,
                       fault_active_i, act_high_force_en, act_low_force_en, act_swap,
                       unlocked};
        end
        popc_pkg::ADDR_MODULE_CTRL: begin
          wb_dat_o <= {30'h00000000, module_ctrl};
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // key protection
  //----------------------------------------------------------------------------
  // every completed access, reads and unmapped ones included, moves the tracker
  popc_unlock u_unlock (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .access_i(bus_done),
    .key_write_i(key_wr),
    .key_data_i(wb_dat_i[15:0]),
    .bypass_i(bypass),
    .write_ok_o(write_ok),
    .unlocked_o(unlocked)
  );

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_ctrl <= popc_pkg::RESET_PIN_CTRL;
    end else if (bus_wr && write_ok && hit(wb_adr_i, popc_pkg::ADDR_PIN_CTRL)) begin
      pin_ctrl <= lane_merge(pin_ctrl, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_limit_control <= popc_pkg::RESET_FAULT_CTRL;
    end else if (bus_wr && write_ok && hit(wb_adr_i, popc_pkg::ADDR_FAULT_CTRL)) begin
      fault_limit_control <= lane_merge(fault_limit_control, wb_dat_i, wb_sel_i);
    end
  end

  // not protected: this register holds the enable and the protection setting
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      module_ctrl <= popc_pkg::RESET_MODULE_CTRL;
    end else if (bus_wr && wb_sel_i[0] && hit(wb_adr_i, popc_pkg::ADDR_MODULE_CTRL)) begin
      module_ctrl <= wb_dat_i[1:0];
    end
  end

  //----------------------------------------------------------------------------
  // override synchronisation
  //----------------------------------------------------------------------------
  // with sync set a mid-cycle change would glitch the bridge, so wait for zero
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_swap <= 1'b0;
      act_high_force_en <= 1'b0;
      act_low_force_en <= 1'b0;
      act_force_levels <= 2'h0;
    end else if (!pin_ctrl.override_sync || tb_zero_i || !module_enable) begin
      act_swap <= pin_ctrl.swap;
      act_high_force_en <= pin_ctrl.high_force_en;
      act_low_force_en <= pin_ctrl.low_force_en;
      act_force_levels <= pin_ctrl.force_levels;
    end
  end

  //----------------------------------------------------------------------------
  // dead-time control inputs
  //----------------------------------------------------------------------------
  always_comb begin
    // exchange sits ahead of dead time so swapped edges still get it
    swapped.high = act_swap ? gen_low_i : gen_high_i;
    swapped.low = act_swap ? gen_high_i : gen_low_i;
    next_dt = swapped;
    // manual force, then limit, then fault: last one wins
    if (act_high_force_en) begin
      next_dt.high = act_force_levels[1];
    end
    if (act_low_force_en) begin
      next_dt.low = act_force_levels[0];
    end
    if (limit_active_i) begin
      next_dt = pin_ctrl.limit_levels;
    end
    if (fault_active_i) begin
      next_dt = pin_ctrl.fault_levels;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dt_high_o <= 1'b0;
      dt_low_o <= 1'b0;
    end else begin
      dt_high_o <= next_dt.high;
      dt_low_o <= next_dt.low;
    end
  end

  //----------------------------------------------------------------------------
  // pin stage
  //----------------------------------------------------------------------------
  always_comb begin
    next_pin.high = dt_high_i;
    next_pin.low = dt_low_i;
    // zero levels cut the output at once instead of waiting out dead time
    if ((fault_active_i && !pin_ctrl.fault_levels[1]) ||
        (!fault_active_i && limit_active_i && !pin_ctrl.limit_levels[1])) begin
      next_pin.high = 1'b0;
    end
    if ((fault_active_i && !pin_ctrl.fault_levels[0]) ||
        (!fault_active_i && limit_active_i && !pin_ctrl.limit_levels[0])) begin
      next_pin.low = 1'b0;
    end
    next_pin.high = next_pin.high ^ pin_ctrl.high_polarity;
    next_pin.low = next_pin.low ^ pin_ctrl.low_polarity;
    // ownership is the top of the priority chain
    if (!module_enable || !pin_ctrl.high_pin_own) begin
      next_pin.high = gpio_high_i;
    end
    if (!module_enable || !pin_ctrl.low_pin_own) begin
      next_pin.low = gpio_low_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_side_out_o <= 1'b0;
      low_side_out_o <= 1'b0;
    end else begin
      high_side_out_o <= next_pin.high;
      low_side_out_o <= next_pin.low;
    end
  end

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  a_swap_route: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (act_swap && !act_high_force_en && !fault_active_i && !limit_active_i)
    |=> dt_high_o == $past(gen_low_i))
    else $error("exchange did not route low waveform to high side");

  a_sync_hold: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (pin_ctrl.override_sync && module_enable && !tb_zero_i) |=> $stable(act_swap))
    else $error("exchange changed away from time-base zero");

  a_zero_load: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (pin_ctrl.override_sync && tb_zero_i) |=> act_swap == $past(pin_ctrl.swap))
    else $error("exchange not loaded at time-base zero");

  a_key_reads_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (ack && !wb_we_i && wb_adr_i == popc_pkg::ADDR_UNLOCK_KEY) |-> wb_dat_o == 32'h0000_0000)
    else $error("key register read returned data");

  a_locked_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (bus_wr && !write_ok && wb_adr_i == popc_pkg::ADDR_PIN_CTRL) |=> $stable(pin_ctrl))
    else $error("protected register written while locked");

  a_fault_first: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    fault_active_i |=> {dt_high_o, dt_low_o} == $past(pin_ctrl.fault_levels))
    else $error("fault levels not on dead-time inputs");

  a_zero_bypass: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (fault_active_i && !pin_ctrl.fault_levels[0] && module_enable &&
     pin_ctrl.low_pin_own && !pin_ctrl.low_polarity) |=> !low_side_out_o)
    else $error("fault zero level did not cut low side at once");

  a_gpio_owner: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    !module_enable |=> (high_side_out_o == $past(gpio_high_i)) &&
                       (low_side_out_o == $past(gpio_low_i)))
    else $error("disabled module did not pass gpio levels");

  a_manual_force: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (act_low_force_en && !fault_active_i && !limit_active_i)
    |=> dt_low_o == $past(act_force_levels[0]))
    else $error("manual force level not applied to low side");

  a_ack_single: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    ack |=> !ack)
    else $error("ack held for more than one cycle");
endmodule

// ===== tb/popc_dt_model.sv
// dead-time unit stand-in that sits between the pin stage control outputs and its drive inputs
`timescale 1ns/1ns
module popc_dt_model #(
  parameter int DEAD = 2
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // control requests from the pin stage
  input wire logic req_high_i,
  input wire logic req_low_i,
  // delayed drive back to the pin stage
  output logic drv_high_o,
  output logic drv_low_o
);
  logic [3:0] cnt_high;
  logic [3:0] cnt_low;

  // turn-on waits the dead time; turn-off passes at once so a shutdown is never late
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_high <= 4'h0;
    end else if (!req_high_i) begin
      cnt_high <= 4'h0;
    end else if (cnt_high != 4'(DEAD)) begin
      cnt_high <= cnt_high + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_low <= 4'h0;
    end else if (!req_low_i) begin
      cnt_low <= 4'h0;
    end else if (cnt_low != 4'(DEAD)) begin
      cnt_low <= cnt_low + 4'h1;
    end
  end

  assign drv_high_o = req_high_i && (cnt_high == 4'(DEAD));
  assign drv_low_o = req_low_i && (cnt_low == 4'(DEAD));
endmodule

// ===== tb/testbench.sv
// self-checking bench for the pwm output pin control block
`timescale 1ns/1ns
module testbench;
  logic ref_clk_i, reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic gen_high_i, gen_low_i, fault_active_i, limit_active_i, tb_zero_i;
  logic dt_high_o, dt_low_o, dt_high_i, dt_low_i, gpio_high_i, gpio_low_i;
  logic high_side_out_o, low_side_out_o;
  int n_fail = 0;
  int comparisons = 0;

  popc_top u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gen_high_i(gen_high_i),
    .gen_low_i(gen_low_i), .fault_active_i(fault_active_i), .limit_active_i(limit_active_i),
    .tb_zero_i(tb_zero_i), .dt_high_o(dt_high_o), .dt_low_o(dt_low_o), .dt_high_i(dt_high_i),
    .dt_low_i(dt_low_i), .gpio_high_i(gpio_high_i), .gpio_low_i(gpio_low_i),
    .high_side_out_o(high_side_out_o), .low_side_out_o(low_side_out_o));

  popc_dt_model #(.DEAD(2)) u_dt (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .req_high_i(dt_high_o), .req_low_i(dt_low_o), .drv_high_o(dt_high_i), .drv_low_o(dt_low_i));

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; request held until ack is sampled, then one idle cycle
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf; // word writes only, so force enables never change by halves
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check("wb_ack_o", {31'h0, wb_ack_o}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    wb_cycle(1'b1, adr, d);
  endtask

  task automatic rdchk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb_cycle(1'b0, adr, 32'h0);
    check(name, rd, exp);
  endtask

  task automatic prot(input logic [7:0] adr, input logic [31:0] d);
    wr(popc_pkg::ADDR_UNLOCK_KEY, 32'h0000_abcd);
    wr(popc_pkg::ADDR_UNLOCK_KEY, 32'h0000_4321);
    wr(adr, d);
  endtask

  // long enough for control register, dead time and pin register to settle
  task automatic settle;
    repeat (8) @(posedge ref_clk_i);
  endtask

  task automatic pins(input string name, input logic [1:0] exp);
    check(name, {30'h0, high_side_out_o, low_side_out_o}, {30'h0, exp});
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //----------------------------------------------------------------------------
  // scenarios
  //----------------------------------------------------------------------------
  task automatic t_reset;
    rdchk("pin_ctrl reset", popc_pkg::ADDR_PIN_CTRL, 32'h0);
    rdchk("key read", popc_pkg::ADDR_UNLOCK_KEY, 32'h0);
    rdchk("unmapped read", 8'h1c, 32'h0);
    pins("pins gpio after reset", 2'b10);
    $display("test reset done");
  endtask

  task automatic t_protect;
    wr(popc_pkg::ADDR_PIN_CTRL, 32'h1234);
    rdchk("locked write", popc_pkg::ADDR_PIN_CTRL, 32'h0);
    prot(popc_pkg::ADDR_PIN_CTRL, 32'h1234);
    rdchk("unlocked write", popc_pkg::ADDR_PIN_CTRL, 32'h1234);
    wr(popc_pkg::ADDR_PIN_CTRL, 32'h0f0f);
    rdchk("second write", popc_pkg::ADDR_PIN_CTRL, 32'h1234);
    wr(popc_pkg::ADDR_UNLOCK_KEY, 32'h0000_abcd);
    rdchk("key read mid", popc_pkg::ADDR_UNLOCK_KEY, 32'h0);
    wr(popc_pkg::ADDR_UNLOCK_KEY, 32'h0000_4321);
    wr(popc_pkg::ADDR_PIN_CTRL, 32'h5555);
    rdchk("key read between", popc_pkg::ADDR_PIN_CTRL, 32'h1234);
    prot(popc_pkg::ADDR_UNLOCK_KEY, 32'h0);
    wr(popc_pkg::ADDR_PIN_CTRL, 32'h5555);
    rdchk("access between", popc_pkg::ADDR_PIN_CTRL, 32'h1234);
    wr(popc_pkg::ADDR_UNLOCK_KEY, 32'h0000_4321);
    wr(popc_pkg::ADDR_UNLOCK_KEY, 32'h0000_abcd);
    wr(popc_pkg::ADDR_PIN_CTRL, 32'h5555);
    rdchk("keys reversed", popc_pkg::ADDR_PIN_CTRL, 32'h1234);
    prot(popc_pkg::ADDR_FAULT_CTRL, 32'h0603);
    rdchk("fault ctrl", popc_pkg::ADDR_FAULT_CTRL, 32'h0603);
    wr(popc_pkg::ADDR_MODULE_CTRL, 32'h2);
    wr(popc_pkg::ADDR_PIN_CTRL, 32'h00aa);
    rdchk("bypass write", popc_pkg::ADDR_PIN_CTRL, 32'h00aa);
    wr(popc_pkg::ADDR_MODULE_CTRL, 32'h0);
    $display("test protect done");
  endtask

  task automatic t_pins;
    gpio_high_i <= 1'b0;
    gpio_low_i <= 1'b1;
    gen_high_i <= 1'b1;
    wr(popc_pkg::ADDR_MODULE_CTRL, 32'h1);
    prot(popc_pkg::ADDR_PIN_CTRL, 32'hc000);
    settle;
    pins("generator", 2'b10);
    prot(popc_pkg::ADDR_PIN_CTRL, 32'hc002);
    settle;
    pins("swapped", 2'b01);
    check("dt swapped", {30'h0, dt_high_o, dt_low_o}, 32'h1);
    prot(popc_pkg::ADDR_PIN_CTRL, 32'h8000);
    settle;
    pins("high owned only", 2'b11);
    wr(popc_pkg::ADDR_MODULE_CTRL, 32'h0);
    settle;
    pins("module off", 2'b01);
    wr(popc_pkg::ADDR_MODULE_CTRL, 32'h1);
    gen_high_i <= 1'b0;
    prot(popc_pkg::ADDR_PIN_CTRL, 32'hc3e4);
    settle;
    pins("forced", 2'b11);
    check("dt forced", {30'h0, dt_high_o, dt_low_o}, 32'h3);
    limit_active_i <= 1'b1;
    settle;
    pins("limit over force", 2'b01);
    fault_active_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    pins("zero level at once", 2'b00);
    settle;
    pins("fault over limit", 2'b10);
    fault_active_i <= 1'b0;
    limit_active_i <= 1'b0;
    $display("test pins done");
  endtask

  task automatic t_sync;
    gen_high_i <= 1'b1;
    // drop the forces first: once sync is set they would stay frozen until zero
    prot(popc_pkg::ADDR_PIN_CTRL, 32'hc000);
    settle;
    prot(popc_pkg::ADDR_PIN_CTRL, 32'hc001);
    settle;
    prot(popc_pkg::ADDR_PIN_CTRL, 32'hc003);
    settle;
    check("swap waits", {30'h0, dt_high_o, dt_low_o}, 32'h2);
    tb_zero_i <= 1'b1;
    @(posedge ref_clk_i);
    tb_zero_i <= 1'b0;
    settle;
    check("swap at zero", {30'h0, dt_high_o, dt_low_o}, 32'h1);
    pins("swap pins", 2'b01);
    rdchk("status", popc_pkg::ADDR_STATUS, 32'h42);
    prot(popc_pkg::ADDR_PIN_CTRL, 32'hd003);
    settle;
    pins("low polarity", 2'b00);
    $display("test sync done");
  endtask

  //----------------------------------------------------------------------------
  // clock, reset, sequence and watchdog
  //----------------------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    reset_n_i = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, tb_zero_i} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    {gen_high_i, gen_low_i, fault_active_i, limit_active_i} = 4'h0;
    gpio_high_i = 1'b1;
    gpio_low_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset;
    t_protect;
    t_pins;
    t_sync;
    give_verdict;
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_fail++;
    $display("[ERR] watchdog expected finish seen timeout");
    give_verdict;
  end
endmodule
